// ==== lpc_counter.sv ====
/*
  Low-power 16-bit pulse/time counter with AXI4-Lite register slave.
  Assumes the four divider clocks and four pulse inputs are asynchronous
  levels sampled here on clk; they must be well below clk/2.
*/
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module lpc_counter (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // AXI4-Lite write address and data.
  input  wire logic [3:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  // AXI4-Lite write response.
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // AXI4-Lite read.
  input  wire logic [3:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Divider clocks, pulse inputs and debug halt.
  input  wire logic [3:0]  div_clk_in,
  input  wire logic [3:0]  pulse_in,
  input  wire logic        debug_halt,
  // Outputs to the system.
  output logic             compare_irq,
  output logic             hw_trigger
);
  localparam int CW = lpc_pkg::CW;

  lpc_pkg::lpc_ctrl_t ctrl_r;
  lpc_pkg::lpc_div_t  divs_r;
  logic [CW-1:0] compare_value_r;
  logic [CW-1:0] count_value_r;
  logic [CW-1:0] snap_r;
  logic          compare_flag_r;
  logic          trig_r;
  logic [3:0]    clk_s1_r, clk_s2_r;
  logic [3:0]    pin_s1_r, pin_s2_r;
  logic          dclk_d_r;
  logic          src_d_r;
  logic [16:0]   dcnt_r;
  logic [1:0]    sync_r;
  logic          filt_r;
  logic          filt_d_r;
  logic          dbg_s1_r, dbg_s2_r;

  // Synchronise every outside level through two flops.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      clk_s1_r <= 4'h0;
      clk_s2_r <= 4'h0;
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      dbg_s1_r <= 1'b0;
      dbg_s2_r <= 1'b0;
    end else begin
      clk_s1_r <= div_clk_in;
      clk_s2_r <= clk_s1_r;
      pin_s1_r <= pulse_in;
      pin_s2_r <= pin_s1_r;
      dbg_s1_r <= debug_halt;
      dbg_s2_r <= dbg_s1_r;
    end
  end

  logic dclk;
  logic dclk_rise;
  logic src_raw;
  logic src;
  logic src_rise;
  logic en;
  logic ready_go;
  logic div_tick;
  logic filt_rise;
  logic advance;
  logic match_adv;
  logic [16:0] period;

  assign en = ctrl_r.enable;
  assign dclk = clk_s2_r[divs_r.clk_sel];  // see R24
  assign dclk_rise = dclk & ~dclk_d_r;
  assign src_raw = pin_s2_r[ctrl_r.input_sel] ^ ctrl_r.active_low;
  // Disabled input reads as asserted so no count appears at enable.
  assign src = en ? src_raw : 1'b1;  // see R13
  assign src_rise = src & ~src_d_r;
  assign ready_go = (sync_r == lpc_pkg::SYNC_DONE);
  assign filt_rise = filt_r & ~filt_d_r;

  // Divide code n: prescaler period 2^(n+1), filter run 2^n samples.
  function automatic logic [16:0] pow2(input logic [4:0] e);
    pow2 = 17'h00001 << e;
  endfunction

  assign period = ctrl_r.pulse_mode ? pow2({1'b0, divs_r.divide})
                                    : pow2({1'b0, divs_r.divide} + 5'h01);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dclk_d_r <= 1'b0;
      src_d_r  <= 1'b1;
      filt_d_r <= 1'b1;
    end else begin
      dclk_d_r <= dclk;
      src_d_r  <= src;
      filt_d_r <= filt_r;
    end
  end

  // Enable synchroniser: two divider clock rises before the divider or filter runs.
  always_ff @(posedge clk) begin
    if (!rstn || !en) begin
      sync_r <= 2'h0;
    end else if (dclk_rise && !ready_go) begin
      sync_r <= sync_r + 2'h1;  // see R06, R12
    end
  end

  // Shared divider: prescaler in time mode, filter run counter in
  // pulse mode. Sharing saves area at the cost of fixed settings.
  always_ff @(posedge clk) begin
    if (!rstn || !en) begin
      dcnt_r <= lpc_pkg::DCNT_RST;
      filt_r <= 1'b1;  // see R08
    end else if (dclk_rise && ready_go) begin  // see R10
      if (!ctrl_r.pulse_mode) begin
        if (dcnt_r + 17'h00001 >= period) begin  // see R03, R05
          dcnt_r <= lpc_pkg::DCNT_RST;
        end else begin
          dcnt_r <= dcnt_r + 17'h00001;
        end
      end else if (src_raw == filt_r) begin
        dcnt_r <= lpc_pkg::DCNT_RST;
      end else if (dcnt_r + 17'h00001 >= period) begin  // see R09
        dcnt_r <= lpc_pkg::DCNT_RST;
        filt_r <= src_raw;
      end else begin
        dcnt_r <= dcnt_r + 17'h00001;
      end
    end
  end

  assign div_tick = dclk_rise && ready_go &&
                    (dcnt_r + 17'h00001 >= period);

  // Pick the advance source for each mode and divider setting.
  always_comb begin
    advance = 1'b0;
    if (en) begin
      if (!ctrl_r.pulse_mode) begin
        if (!dbg_s2_r) begin  // see R17
          advance = divs_r.bypass ? (dclk_rise && ready_go)  // see R07
                                  : div_tick;  // see R23
        end
      end else if (divs_r.bypass) begin
        advance = src_rise;  // see R02
      end else begin
        advance = filt_rise;  // see R11
      end
    end
  end

  assign match_adv = advance && (count_value_r == compare_value_r);

  // Counter: wraps, clears on match unless free running, zero when off.
  always_ff @(posedge clk) begin
    if (!rstn || !en) begin
      count_value_r <= lpc_pkg::CNT_RST;  // see R16
    end else if (match_adv && !ctrl_r.free_run) begin
      count_value_r <= lpc_pkg::CNT_RST;  // see R14
    end else if (advance) begin
      count_value_r <= count_value_r + 16'h0001;  // see R25
    end
  end

  // Trigger sets with the flag and drops on the next advance; a zero compare without free run holds it.
  always_ff @(posedge clk) begin
    if (!rstn || !en) begin
      trig_r <= 1'b0;
    end else if (match_adv) begin
      trig_r <= 1'b1;  // see R20
    end else if (advance &&
                 !(compare_value_r == 16'h0000 && !ctrl_r.free_run)) begin
      trig_r <= 1'b0;  // see R21
    end
  end

  // Bus slave: write address and data may arrive in either order.
  logic       aw_held_r, w_held_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic       do_write;

  assign s_awready = !aw_held_r && !s_bvalid;
  assign s_wready  = !w_held_r && !s_bvalid;
  assign do_write  = aw_held_r && w_held_r && !s_bvalid;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 4'h0;
      wdata_r   <= 32'h00000000;
      s_bvalid  <= 1'b0;
      s_bresp   <= lpc_pkg::RESP_OK;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_wdata;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= (awaddr_r[1:0] == 2'h0) ? lpc_pkg::RESP_OK
                                             : lpc_pkg::RESP_ERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  logic wr_ctrl, wr_div, wr_cmp, wr_cnt;
  assign wr_ctrl = do_write && awaddr_r == lpc_pkg::OFS_CTRL;
  assign wr_div  = do_write && awaddr_r == lpc_pkg::OFS_DIV;
  assign wr_cmp  = do_write && awaddr_r == lpc_pkg::OFS_CMP;
  assign wr_cnt  = do_write && awaddr_r == lpc_pkg::OFS_CNT;

  // Registers take whole-word writes; byte strobes are not split.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r          <= '0;
      divs_r          <= '0;
      compare_value_r <= lpc_pkg::CNT_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r.enable     <= wdata_r[lpc_pkg::B_EN];
        ctrl_r.pulse_mode <= wdata_r[lpc_pkg::B_MODE];
        ctrl_r.free_run   <= wdata_r[lpc_pkg::B_FREE];
        ctrl_r.active_low <= wdata_r[lpc_pkg::B_POL];
        ctrl_r.input_sel  <= wdata_r[lpc_pkg::B_INSL +: 2];
        ctrl_r.irq_en     <= wdata_r[lpc_pkg::B_IE];
      end
      if (wr_div) begin
        divs_r.clk_sel <= wdata_r[lpc_pkg::B_CSEL +: 2];
        divs_r.bypass  <= wdata_r[lpc_pkg::B_BYP];
        divs_r.divide  <= wdata_r[lpc_pkg::B_DIV +: 4];
      end
      if (wr_cmp) begin
        compare_value_r <= wdata_r[CW-1:0];
      end
    end
  end

  // Flag: set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!rstn || !en) begin
      compare_flag_r <= 1'b0;
    end else if (match_adv) begin
      compare_flag_r <= 1'b1;  // see R14
    end else if (wr_ctrl && wdata_r[lpc_pkg::B_FLAG]) begin
      compare_flag_r <= 1'b0;  // see R22
    end
  end

  // Any write to the count address captures the synchronous count.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      snap_r <= lpc_pkg::CNT_RST;
    end else if (wr_cnt) begin
      snap_r <= count_value_r;  // see R18
    end
  end

  assign compare_irq = ctrl_r.irq_en & compare_flag_r;  // see R22
  assign hw_trigger  = trig_r;

  // Read channel: one-cycle answer, unmapped offsets give an error.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h00000000;
    unique case (s_araddr)
      lpc_pkg::OFS_CTRL: begin
        rd_word[lpc_pkg::B_EN]        = ctrl_r.enable;
        rd_word[lpc_pkg::B_MODE]      = ctrl_r.pulse_mode;
        rd_word[lpc_pkg::B_FREE]      = ctrl_r.free_run;
        rd_word[lpc_pkg::B_POL]       = ctrl_r.active_low;
        rd_word[lpc_pkg::B_INSL +: 2] = ctrl_r.input_sel;
        rd_word[lpc_pkg::B_IE]        = ctrl_r.irq_en;
        rd_word[lpc_pkg::B_FLAG]      = compare_flag_r;
      end
      lpc_pkg::OFS_DIV: begin
        rd_word[lpc_pkg::B_CSEL +: 2] = divs_r.clk_sel;
        rd_word[lpc_pkg::B_BYP]       = divs_r.bypass;
        rd_word[lpc_pkg::B_DIV +: 4]  = divs_r.divide;
      end
      lpc_pkg::OFS_CMP: rd_word[CW-1:0] = compare_value_r;
      lpc_pkg::OFS_CNT: rd_word[CW-1:0] = snap_r;
      default: rd_word = 32'h00000000;
    endcase
  end

  assign s_arready = !s_rvalid;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h00000000;
      s_rresp  <= lpc_pkg::RESP_OK;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_word;
      s_rresp  <= (s_araddr[1:0] == 2'h0) ? lpc_pkg::RESP_OK
                                          : lpc_pkg::RESP_ERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // Checks on the block's own behaviour.
  property p_flag_on_match;
    @(posedge clk) disable iff (!rstn)
      match_adv |=> compare_flag_r && hw_trigger;
  endproperty
  a_flag_on_match: assert property (p_flag_on_match)  // see R14
    else $error("flag or trigger missing after match");

  property p_clear_on_match;
    @(posedge clk) disable iff (!rstn)
      match_adv && !ctrl_r.free_run && en |=> count_value_r == 16'h0000;
  endproperty
  a_clear_on_match: assert property (p_clear_on_match)  // see R14
    else $error("counter not cleared on match");

  property p_zero_when_off;
    @(posedge clk) disable iff (!rstn)
      !en |=> count_value_r == 16'h0000 && !compare_flag_r;
  endproperty
  a_zero_when_off: assert property (p_zero_when_off)  // see R16
    else $error("counter or flag not cleared when disabled");

  property p_irq_and;
    @(posedge clk) disable iff (!rstn)
      compare_irq == (ctrl_r.irq_en && compare_flag_r);
  endproperty
  a_irq_and: assert property (p_irq_and)  // see R22
    else $error("interrupt not enable AND flag");

  property p_trig_drop;
    @(posedge clk) disable iff (!rstn)
      hw_trigger && advance && !match_adv && en &&
      (compare_value_r != 16'h0000 || ctrl_r.free_run) |=> !hw_trigger;
  endproperty
  a_trig_drop: assert property (p_trig_drop)  // see R21
    else $error("trigger did not drop on next advance");

  property p_halt_time;
    @(posedge clk) disable iff (!rstn)
      !ctrl_r.pulse_mode && dbg_s2_r |-> !advance;
  endproperty
  a_halt_time: assert property (p_halt_time)  // see R17
    else $error("time mode advanced during debug halt");

  sequence s_enable_rise;
    !en ##1 en;
  endsequence
  property p_sync_delay;
    @(posedge clk) disable iff (!rstn)
      s_enable_rise |-> !div_tick && sync_r == 2'h0;
  endproperty
  a_sync_delay: assert property (p_sync_delay)  // see R06
    else $error("divider ran before enable synchronisation");

  property p_snapshot;
    @(posedge clk) disable iff (!rstn)
      wr_cnt |=> snap_r == $past(count_value_r);
  endproperty
  a_snapshot: assert property (p_snapshot)  // see R18
    else $error("snapshot does not hold the count");

  property p_filter_start;
    @(posedge clk) disable iff (!rstn)
      s_enable_rise |-> filt_r;
  endproperty
  a_filter_start: assert property (p_filter_start)  // see R08
    else $error("filter did not start asserted");
endmodule

// ==== lpc_pkg.sv ====
/*
  Package for the low-power pulse/time counter: register map, field
  positions, reset values and the packed structs used by the block.
  Assumes an AXI4-Lite master on the same clock as the counter.
*/
// How it works
// R01: Software picks and starts divider clock first.
// R02: Unfiltered pulse mode counts input edges directly.
// R03: One divider serves as prescaler and filter.
// R04: Software keeps divider settings while enabled.
// R05: Prescaled time mode counts every 2^(n+1) clocks.
// R06: First time advance delayed one/two clocks.
// R07: Bypassed time mode counts every selected clock.
// R08: Filter output starts asserted at enable.
// R09: Filter changes after 2^n stable samples.
// R10: Filter samples only on divider clock rises.
// R11: Filtered pulse mode counts filter output assertions.
// R12: Filter waits one/two extra edges at enable.
// R13: Unfiltered input forced asserted while disabled.
// R14: Match and advance sets flag, trigger, clears.
// R15: Software changes compare only while flag set.
// R16: Counter zero when disabled or overflowed.
// R17: Debug halt stops time mode, not pulse.
// R18: Write to count latches snapshot for reads.
// R19: Bus clock at least twice count rate.
// R20: Trigger asserts with compare flag set.
// R21: Zero compare without free-run holds trigger.
// R22: Interrupt is enable AND flag; write-one clears.
// R23: Bypass 0 uses divider, 1 skips it.
// R24: Two-bit select picks divider clock 0..3.
// R25: Counter and compare are 16 bits, wrapping.
package lpc_pkg;
  localparam int CW = 16;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_DIV  = 4'h4;
  localparam logic [3:0] OFS_CMP  = 4'h8;
  localparam logic [3:0] OFS_CNT  = 4'hC;
  // Control/status word bit positions.
  localparam int B_EN   = 0;
  localparam int B_MODE = 1;
  localparam int B_FREE = 2;
  localparam int B_POL  = 3;
  localparam int B_INSL = 4;
  localparam int B_IE   = 6;
  localparam int B_FLAG = 7;
  // Divider settings bit positions.
  localparam int B_CSEL = 0;
  localparam int B_BYP  = 2;
  localparam int B_DIV  = 3;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [CW-1:0] CNT_RST = 16'h0000;
  localparam logic [16:0] DCNT_RST = 17'h00000;
  // Divider rises spent on enable synchronisation.
  localparam logic [1:0] SYNC_DONE = 2'h2;
  typedef struct packed {
    logic       enable;
    logic       pulse_mode;
    logic       free_run;
    logic       active_low;
    logic [1:0] input_sel;
    logic       irq_en;
  } lpc_ctrl_t;
  typedef struct packed {
    logic [3:0] divide;
    logic       bypass;
    logic [1:0] clk_sel;
  } lpc_div_t;
endpackage

// ==== lpc_src.sv ====
/*
  Far-side model: four divider clocks and four pulse inputs.
  Assumes clk is the counter's clock and that the bench calls its tasks.
*/
`timescale 1ns/100ps
module lpc_src (
  // Block clock.
  input  wire logic clk,
  // Levels seen by the counter.
  output logic [3:0] div_clk_in,
  output logic [3:0] pulse_in
);
  // Idle clocks stand still low, so no stray rise reaches the divider.
  initial begin
    div_clk_in = 4'h0;
    pulse_in   = 4'h0;
  end

  // Four cycles high and five low keep each source well below half the bus rate.
  task automatic run_clk(input int sel, input int n);
    repeat (n) begin
      @(posedge clk) div_clk_in[sel] <= 1'b1;
      repeat (4) @(posedge clk);
      div_clk_in[sel] <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic set_pulse(input int sel, input logic v);
    @(posedge clk) pulse_in[sel] <= v;
    repeat (4) @(posedge clk);
  endtask

  task automatic run_pulse(input int sel, input int n);
    repeat (n) begin
      set_pulse(sel, 1'b0);
      set_pulse(sel, 1'b1);
    end
  endtask
endmodule

// ==== tb.sv ====
/*
  Self-checking bench for the pulse/time counter.
  Assumes lpc_pkg and lpc_src are compiled first.
*/
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [3:0]  a;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [1:0]  rs;
  } lpc_row_t;
  logic        clk, rstn, debug_halt;
  logic [3:0]  s_awaddr, s_araddr, s_wstrb;
  logic [31:0] s_wdata, s_rdata, rdat;
  logic        s_awvalid, s_awready, s_wvalid, s_wready;
  logic        s_bvalid, s_bready, s_arvalid, s_arready;
  logic        s_rvalid, s_rready, compare_irq, hw_trigger;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic [3:0]  div_clk_in, pulse_in;
  int          fails, check_count;
  lpc_row_t    rows [5] = '{
    '{4'h0, 32'hFFFF_FF7E, 32'h0000_007E, 2'h0},
    '{4'h4, 32'hFFFF_FFFF, 32'h0000_007F, 2'h0},
    '{4'h8, 32'hFFFF_1234, 32'h0000_1234, 2'h0},
    '{4'hC, 32'h0000_5555, 32'h0000_0000, 2'h0},
    '{4'h2, 32'h0000_0001, 32'h0000_0000, 2'h2}};

  lpc_counter i_dut (
    .clk         (clk),
    .rstn        (rstn),
    .s_awaddr    (s_awaddr),
    .s_awvalid   (s_awvalid),
    .s_awready   (s_awready),
    .s_wdata     (s_wdata),
    .s_wstrb     (s_wstrb),
    .s_wvalid    (s_wvalid),
    .s_wready    (s_wready),
    .s_bresp     (s_bresp),
    .s_bvalid    (s_bvalid),
    .s_bready    (s_bready),
    .s_araddr    (s_araddr),
    .s_arvalid   (s_arvalid),
    .s_arready   (s_arready),
    .s_rdata     (s_rdata),
    .s_rresp     (s_rresp),
    .s_rvalid    (s_rvalid),
    .s_rready    (s_rready),
    .div_clk_in  (div_clk_in),
    .pulse_in    (pulse_in),
    .debug_halt  (debug_halt),
    .compare_irq (compare_irq),
    .hw_trigger  (hw_trigger)
  );
  lpc_src i_src (.clk(clk), .div_clk_in(div_clk_in), .pulse_in(pulse_in));

  always #50 clk = ~clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic hang(input int n);
    if (n >= 50) begin
      fails++;
      $display("[ERR] %0t ns: bus wait ran out", $time);
      finish_test();
    end
  endtask

  // Ready is sampled at the falling edge, where it already stands for
  // the next rising edge, so the release never races the design.
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    logic ta, tw;
    n = 0;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    while (!(ta && tw) && n < 50) begin
      @(negedge clk);
      if (s_awvalid && s_awready === 1'b1) ta = 1'b1;
      if (s_wvalid && s_wready === 1'b1) tw = 1'b1;
      @(posedge clk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
      n++;
    end
    hang(n);
    s_bready <= 1'b1;
    n = 0;
    tw = 1'b0;
    while (!tw && n < 50) begin
      @(negedge clk);
      tw = (s_bvalid === 1'b1);
      r = s_bresp;
      @(posedge clk);
      n++;
    end
    s_bready <= 1'b0;
    hang(n);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    @(posedge clk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    while (!ok && n < 50) begin
      @(negedge clk);
      ok = (s_arready === 1'b1);
      @(posedge clk);
      n++;
    end
    s_arvalid <= 1'b0;
    s_rready  <= 1'b1;
    hang(n);
    n = 0;
    ok = 1'b0;
    while (!ok && n < 50) begin
      @(negedge clk);
      ok = (s_rvalid === 1'b1);
      d = s_rdata;
      r = s_rresp;
      @(posedge clk);
      n++;
    end
    s_rready <= 1'b0;
    hang(n);
  endtask

  // The block is always configured from the disabled state.
  task automatic cfg(input logic [31:0] dv, cm, ct);
    wr(lpc_pkg::OFS_CTRL, 32'h0, rsp);
    wr(lpc_pkg::OFS_DIV, dv, rsp);
    wr(lpc_pkg::OFS_CMP, cm, rsp);
    wr(lpc_pkg::OFS_CTRL, ct, rsp);
  endtask

  task automatic cnt_is(input logic [31:0] e);
    wr(lpc_pkg::OFS_CNT, 32'h0, rsp);
    rd(lpc_pkg::OFS_CNT, rdat, rsp);
    chk(rdat, e);
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    debug_halt = 1'b0;
    {s_awaddr, s_araddr, s_wstrb, s_wdata} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    fails = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({30'h0, compare_irq, hw_trigger}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(4'(4 * i), rdat, rsp);
      chk(rdat, 32'h0);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd, rsp);
      chk({30'h0, rsp}, {30'h0, rows[i].rs});
      rd(rows[i].a, rdat, rsp);
      chk({30'h0, rsp}, {30'h0, rows[i].rs});
      if (rows[i].rs === 2'h0) chk(rdat, rows[i].rd);
    end
    for (int s = 0; s < 4; s++) begin
      cfg(32'h4 | s, 32'hFFFF, 32'h1);
      i_src.run_clk(s, 4);
      i_src.run_clk((s + 1) % 4, 3);
      cnt_is(32'h2);
      wr(lpc_pkg::OFS_CTRL, 32'h0, rsp);
      cnt_is(32'h0);
    end
    for (int d = 0; d < 4; d += 3) begin
      cfg(32'(d << 3), 32'hFFFF, 32'h1);
      i_src.run_clk(0, 3 + (2 << d) * 2);
      cnt_is(32'h2);
    end
    cfg(32'h4, 32'h2, 32'h41);
    i_src.run_clk(0, 5);
    chk({30'h0, compare_irq, hw_trigger}, 32'h3);
    rd(lpc_pkg::OFS_CTRL, rdat, rsp);
    chk(rdat, 32'hC1);
    cnt_is(32'h0);
    i_src.run_clk(0, 1);
    chk({31'h0, hw_trigger}, 32'h0);
    wr(lpc_pkg::OFS_CTRL, 32'hC1, rsp);
    chk({31'h0, compare_irq}, 32'h0);
    cfg(32'h4, 32'h2, 32'h5);
    i_src.run_clk(0, 5);
    chk({30'h0, compare_irq, hw_trigger}, 32'h1);
    cnt_is(32'h3);
    cfg(32'h4, 32'h0, 32'h1);
    i_src.run_clk(0, 5);
    chk({31'h0, hw_trigger}, 32'h1);
    // A reset in mid-run must drop the held trigger and the count.
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({31'h0, hw_trigger}, 32'h0);
    cnt_is(32'h0);
    cfg(32'h4, 32'hFFFF, 32'h1);
    @(posedge clk) debug_halt <= 1'b1;
    i_src.run_clk(0, 4);
    cnt_is(32'h0);
    i_src.set_pulse(1, 1'b1);
    cfg(32'h4, 32'hFFFF, 32'h13);
    i_src.run_pulse(1, 3);
    cnt_is(32'h3);
    @(posedge clk) debug_halt <= 1'b0;
    // A single high sample is a glitch for a two-sample filter run.
    i_src.set_pulse(0, 1'b0);
    cfg(32'h8, 32'hFFFF, 32'h3);
    i_src.run_clk(0, 8);
    i_src.set_pulse(0, 1'b1);
    i_src.run_clk(0, 1);
    i_src.set_pulse(0, 1'b0);
    i_src.run_clk(0, 4);
    cnt_is(32'h0);
    i_src.set_pulse(0, 1'b1);
    i_src.run_clk(0, 4);
    cnt_is(32'h1);
    // An active-low input already asserted at enable must not count.
    i_src.set_pulse(0, 1'b0);
    cfg(32'h8, 32'hFFFF, 32'hB);
    i_src.run_clk(0, 6);
    cnt_is(32'h0);
    cfg(32'h4, 32'hFFFF, 32'hB);
    i_src.run_pulse(0, 3);
    cnt_is(32'h2);
    finish_test();
  end
endmodule
